// ==== verilog/dbg_apb_pkg.sv ====
// shared types and constants for the debug apb interconnect
// assumes apb4 requesters and completers on one clock, synchronous pins
// How it works
// - one to four requesters, up to 64 completers
// - lowest requester index wins the grant
// - request age plays no part in arbitration
// - arbitration repeats after each completed access
// - completer error is passed back upstream
// - unmapped address finishes locally with error
// - address width is a design parameter
// - completers grouped into expander sub-modules
// - q-channel lets clock controller gate clock
package dbg_apb_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int MAX_REQ = 4;
  localparam int MAX_CMP = 64;
  // completer window size, log2 of bytes per completer
  localparam int SLOT_BITS = 12;
  // idle cycles before the clock may be handed off
  localparam int QIDLE_CYCLES = 2;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [3:0] strb;
    logic [2:0] prot;
  } apb_req_t;

  typedef struct packed {
    logic ready;
    logic slverr;
    logic [DATA_W-1:0] rdata;
  } apb_rsp_t;

  typedef enum logic [1:0] {
    Q_RUN = 2'b00,
    Q_STOPPED = 2'b01,
    Q_DENY = 2'b10
  } q_state_t;
endpackage

// ==== verilog/dbg_apb_expander.sv ====
// expander: fans one downstream request out to a group of completers
// assumes the decoder gives a one-hot local select within the group
`timescale 1ns/1ps
module dbg_apb_expander #(
  parameter int N_PORTS = 4
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // upstream side from the decoder
  input dbg_apb_pkg::apb_req_t up_req,
  input wire logic [N_PORTS-1:0] up_hit,
  output dbg_apb_pkg::apb_rsp_t up_rsp,
  // completer side
  output dbg_apb_pkg::apb_req_t [N_PORTS-1:0] dn_req,
  input dbg_apb_pkg::apb_rsp_t [N_PORTS-1:0] dn_rsp
);
  dbg_apb_pkg::apb_rsp_t mux_rsp;

  // select reaches only the hit port; response taken back from it
  always_comb begin
    mux_rsp = '0;
    for (int i = 0; i < N_PORTS; i++) begin
      if (up_hit[i]) begin
        mux_rsp = dn_rsp[i];
      end
    end
  end

  // registered outputs cost one cycle per phase, but give clean timing
  for (genvar g = 0; g < N_PORTS; g++) begin : g_port
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        dn_req[g] <= '0;
      end else begin
        dn_req[g] <= up_req;
        dn_req[g].sel <= up_req.sel & up_hit[g] & ~(dn_req[g].enable & dn_rsp[g].ready);
        dn_req[g].enable <= up_req.enable & up_hit[g] & ~(dn_req[g].enable & dn_rsp[g].ready);
      end
    end
  end

  assign up_rsp = mux_rsp;
endmodule // dbg_apb_expander

// ==== verilog/dbg_apb_interconnect.sv ====
// debug apb interconnect: arbiter, address decoder, q-channel
// assumes apb4 requesters that hold their request until PREADY
`timescale 1ns/1ps
module dbg_apb_interconnect #(
  parameter int N_REQ = dbg_apb_pkg::MAX_REQ,
  parameter int N_CMP = dbg_apb_pkg::MAX_CMP,
  parameter int N_GRP = 2,
  parameter int A_W = dbg_apb_pkg::ADDR_W
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // upstream requesters
  input dbg_apb_pkg::apb_req_t [N_REQ-1:0] UP_REQ,
  output dbg_apb_pkg::apb_rsp_t [N_REQ-1:0] UP_RSP,
  // downstream completers
  output dbg_apb_pkg::apb_req_t [N_CMP-1:0] DN_REQ,
  input dbg_apb_pkg::apb_rsp_t [N_CMP-1:0] DN_RSP,
  // q-channel
  input wire logic QREQ_N,
  output logic QACCEPT_N,
  output logic QDENY,
  output logic QACTIVE
);
  localparam int PER_GRP = N_CMP / N_GRP;
  localparam int IW = (N_REQ > 1) ? $clog2(N_REQ) : 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_WAIT = 2'b10,
    ST_DONE = 2'b11
  } st_t;

  // fixed priority pick: lowest index among pending
  function automatic logic [IW-1:0] pick(input logic [N_REQ-1:0] p);
    pick = '0;
    for (int i = N_REQ - 1; i >= 0; i--) begin
      if (p[i]) begin
        pick = IW'(i);
      end
    end
  endfunction

  st_t state;
  st_t next_state;
  logic [IW-1:0] owner;
  logic [N_REQ-1:0] pending;
  logic any_pending;
  logic [A_W-1:0] cur_addr;
  logic [N_CMP-1:0] hit;
  logic mapped;
  dbg_apb_pkg::apb_req_t fwd;
  dbg_apb_pkg::apb_req_t [N_GRP-1:0] grp_req;
  dbg_apb_pkg::apb_rsp_t [N_GRP-1:0] grp_rsp;
  dbg_apb_pkg::apb_rsp_t sel_rsp;
  dbg_apb_pkg::apb_rsp_t [N_REQ-1:0] up_rsp_q;
  logic in_stop;
  logic [1:0] idle_cnt;
  logic q_idle;
  logic acc_q;
  logic dn_ready;
  logic [N_REQ-1:0] rsp_ready;
  logic [N_REQ-1:0] pend_q;
  logic [N_REQ-1:0] below_owner;

  // pending view; time of arrival is not stored anywhere
  for (genvar r = 0; r < N_REQ; r++) begin : g_pend
    assign pending[r] = UP_REQ[r].sel;
  end
  assign any_pending = |pending & ~in_stop;

  // decode on the owner's address into completer slots
  assign cur_addr = A_W'(UP_REQ[owner].addr);
  for (genvar c = 0; c < N_CMP; c++) begin : g_dec
    assign hit[c] = (cur_addr >> dbg_apb_pkg::SLOT_BITS) == A_W'(c);
  end
  assign mapped = |hit;

  // forwarded request only in the active phases and only if mapped
  always_comb begin
    fwd = UP_REQ[owner];
    fwd.sel = mapped & (state == ST_SETUP || state == ST_WAIT);
    fwd.enable = mapped & (state == ST_WAIT);
  end

  // expanders each serve a slice of the completers
  for (genvar g = 0; g < N_GRP; g++) begin : g_grp
    assign grp_req[g] = fwd;
    dbg_apb_expander #(.N_PORTS(PER_GRP)) u_exp (
      .CLK(CLK),
      .RST_N(RST_N),
      .up_req(grp_req[g]),
      .up_hit(hit[g*PER_GRP +: PER_GRP]),
      .up_rsp(grp_rsp[g]),
      .dn_req(DN_REQ[g*PER_GRP +: PER_GRP]),
      .dn_rsp(DN_RSP[g*PER_GRP +: PER_GRP])
    );
  end

  always_comb begin
    sel_rsp = '0;
    for (int g = 0; g < N_GRP; g++) begin
      if (|hit[g*PER_GRP +: PER_GRP]) begin
        sel_rsp = grp_rsp[g];
      end
    end
  end

  // completer ready counts only in the access phase; apb lets it float high before
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      acc_q <= 1'b0;
    end else begin
      acc_q <= fwd.enable & ~(acc_q & sel_rsp.ready);
    end
  end
  assign dn_ready = sel_rsp.ready & acc_q;

  // grant sequence; wait holds the owner until ready
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (any_pending) next_state = ST_SETUP;
      ST_SETUP: next_state = ST_WAIT;
      ST_WAIT: if (!mapped || dn_ready) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      owner <= '0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && any_pending) begin
        owner <= pick(pending);
      end
    end
  end

  // upstream answer: one ready pulse to the owner, low for all others
  for (genvar r = 0; r < N_REQ; r++) begin : g_rsp
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        up_rsp_q[r] <= '0;
      end else if (state == ST_WAIT && next_state == ST_DONE && owner == IW'(r)) begin
        up_rsp_q[r].ready <= 1'b1;
        up_rsp_q[r].slverr <= ~mapped | sel_rsp.slverr;
        up_rsp_q[r].rdata <= mapped ? sel_rsp.rdata : '0;
      end else begin
        up_rsp_q[r] <= '0;
      end
    end
    assign rsp_ready[r] = up_rsp_q[r].ready;
  end
  assign UP_RSP = up_rsp_q;

  // accept needs no request this cycle too, or a grant and a stop would meet
  assign q_idle = state == ST_IDLE && pending == '0 &&
    idle_cnt == 2'(dbg_apb_pkg::QIDLE_CYCLES);

  // q-channel: accept only when idle for a while, deny while a transfer runs, otherwise wait
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      QACCEPT_N <= 1'b1;
      QDENY <= 1'b0;
      QACTIVE <= 1'b0;
      in_stop <= 1'b0;
      idle_cnt <= '0;
    end else begin
      QACTIVE <= |pending | (state != ST_IDLE);
      if (state != ST_IDLE || |pending) begin
        idle_cnt <= '0;
      end else if (idle_cnt != 2'(dbg_apb_pkg::QIDLE_CYCLES)) begin
        idle_cnt <= idle_cnt + 2'h1;
      end
      if (!QREQ_N && QACCEPT_N && !QDENY) begin
        if (q_idle) begin
          QACCEPT_N <= 1'b0;
          in_stop <= 1'b1;
        end else if (state != ST_IDLE) begin
          QDENY <= 1'b1;
        end
      end else if (QREQ_N) begin
        QACCEPT_N <= 1'b1;
        QDENY <= 1'b0;
        in_stop <= 1'b0;
      end
    end
  end

  // pending snapshot, so the grant check does not lean on the pick function
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pend_q <= '0;
    end else begin
      pend_q <= pending;
    end
  end
  assign below_owner = (N_REQ'(1) << owner) - N_REQ'(1);

  // assertions
  AST_LOWEST_WINS: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ST_IDLE && any_pending) |=> pend_q[owner] && (pend_q & below_owner) == '0)
    else $error("grant not to lowest index");
  AST_NO_AGE: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ST_IDLE && any_pending && pending[0]) |=> owner == '0)
    else $error("requester 0 lost arbitration");
  AST_REARB: assert property (@(posedge CLK) disable iff (!RST_N)
    state == ST_DONE |=> state == ST_IDLE)
    else $error("no return to arbitration");
  AST_ERR_PASS: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ST_WAIT && mapped && dn_ready && sel_rsp.slverr)
      |=> UP_RSP[$past(owner)].slverr)
    else $error("completer error dropped");
  sequence s_unmapped;
    state == ST_SETUP ##1 (state == ST_WAIT && !mapped);
  endsequence
  AST_UNMAPPED: assert property (@(posedge CLK) disable iff (!RST_N)
    s_unmapped |=> UP_RSP[$past(owner)].ready && UP_RSP[$past(owner)].slverr)
    else $error("unmapped access without error");
  AST_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ST_WAIT && mapped && !dn_ready) |=> $stable(owner) && state == ST_WAIT)
    else $error("owner changed mid transfer");
  AST_SETUP_READY: assert property (@(posedge CLK) disable iff (!RST_N)
    (state == ST_WAIT && mapped && !acc_q) |=> state == ST_WAIT)
    else $error("transfer ended before its access phase");
  AST_OTHERS_LOW: assert property (@(posedge CLK) disable iff (!RST_N)
    state != ST_DONE |-> rsp_ready == '0)
    else $error("ready outside completion");
  AST_ONE_READY: assert property (@(posedge CLK) disable iff (!RST_N)
    $onehot0(rsp_ready))
    else $error("ready to more than one requester");
  AST_Q_IDLE: assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(QACCEPT_N) |-> $past(state) == ST_IDLE && state == ST_IDLE && pend_q == '0)
    else $error("clock handed off while busy");
  AST_Q_HOLD: assert property (@(posedge CLK) disable iff (!RST_N)
    (in_stop && state == ST_IDLE) |=> state == ST_IDLE)
    else $error("grant issued while clock stopped");
endmodule // dbg_apb_interconnect

// ==== verif/dbg_cmp_model.sv ====
// completer model: one apb4 completer per downstream port
// assumes psel and penable come from the interconnect on one clock
`timescale 1ns/1ps
module dbg_cmp_model #(
  parameter int N = 8
) (
  // clock
  input wire logic clk,
  // downstream bus
  input dbg_apb_pkg::apb_req_t [N-1:0] req,
  output dbg_apb_pkg::apb_rsp_t [N-1:0] rsp,
  // last completed access, so the bench can check routing
  output dbg_apb_pkg::apb_req_t seen
);
  logic [1:0] cnt [N];
  logic [N-1:0] done;
  // completer 3 adds two wait states and completer 7 always errors
  for (genvar c = 0; c < N; c++) begin : g_c
    wire logic go = req[c].sel && req[c].enable;
    wire logic rdy = go && cnt[c] == (c == 3 ? 2'h2 : 2'h0);
    wire logic [31:0] val = {16'hC0DE, 8'h00, 8'(c)};
    // outside the access phase all but completer 3 leave ready high, as apb allows
    assign rsp[c].ready = rdy | (!go && c != 3);
    assign rsp[c].slverr = rdy && c == 7;
    // data outside ready is inverted, so a stale sample cannot pass
    assign rsp[c].rdata = rdy ? val : ~val;
    // wait-state counter
    always_ff @(posedge clk) cnt[c] <= (go && !rdy) ? cnt[c] + 2'h1 : 2'h0;
    assign done[c] = rdy;
  end

  // keep the request of whichever port completes
  always_ff @(posedge clk) begin
    for (int i = 0; i < N; i++) begin
      if (done[i]) begin
        seen <= req[i];
      end
    end
  end
endmodule // dbg_cmp_model

// ==== verif/tb_top.sv ====
// self-checking bench for the debug apb interconnect
// assumes the completer model on all eight downstream ports
`timescale 1ns/1ps
module tb_top;
  `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: %h vs %h", $time, a, e); end end
  typedef struct {
    logic [3:0] mask;
    logic [31:0] addr;
    logic write;
    logic err;
    logic [31:0] rd;
  } row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic qreq_n = 1'b1;
  logic qaccept_n, qdeny, qactive;
  dbg_apb_pkg::apb_req_t [3:0] up_req = '0;
  dbg_apb_pkg::apb_rsp_t [3:0] up_rsp;
  dbg_apb_pkg::apb_req_t [7:0] dn_req;
  dbg_apb_pkg::apb_rsp_t [7:0] dn_rsp;
  dbg_apb_pkg::apb_req_t seen;
  int miscompares = 0;
  int comparisons = 0;
  // ordinary cases; rdata is only compared on error-free reads
  row_t rows[6] = '{
    '{4'h1, 32'h0000_0010, 1'b0, 1'b0, 32'hC0DE_0000},
    '{4'h4, 32'h0000_3004, 1'b0, 1'b0, 32'hC0DE_0003},
    '{4'h2, 32'h0000_7000, 1'b0, 1'b1, 32'h0000_0000},
    '{4'h8, 32'h0000_8000, 1'b0, 1'b1, 32'h0000_0000},
    '{4'hF, 32'h0000_1008, 1'b0, 1'b0, 32'hC0DE_0001},
    '{4'hA, 32'h0000_2000, 1'b1, 1'b0, 32'h0000_0000}};

  dbg_apb_interconnect #(.N_REQ(4), .N_CMP(8), .N_GRP(2)) uut (
    .CLK(clk), .RST_N(rst_n), .UP_REQ(up_req), .UP_RSP(up_rsp), .DN_REQ(dn_req),
    .DN_RSP(dn_rsp), .QREQ_N(qreq_n), .QACCEPT_N(qaccept_n), .QDENY(qdeny),
    .QACTIVE(qactive));
  dbg_cmp_model #(.N(8)) cmp (.clk(clk), .req(dn_req), .rsp(dn_rsp), .seen(seen));

  // 40 MHz clock
  initial forever #12.5 clk = ~clk;

  task automatic report_and_stop;
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // setup phase on every requester of the mask, access phase one edge later
  task automatic raise(input logic [3:0] m, input logic [31:0] a, input logic w);
    for (int i = 0; i < 4; i++) if (m[i]) begin
      up_req[i].addr <= a;
      up_req[i].write <= w;
      up_req[i].wdata <= ~a;
      up_req[i].strb <= 4'hF;
      up_req[i].sel <= 1'b1;
    end
    @(posedge clk);
    for (int i = 0; i < 4; i++) if (m[i]) up_req[i].enable <= 1'b1;
  endtask

  // answers must arrive one owner at a time in the given order
  task automatic collect(input int ord[4], input int n, input logic err,
                         input logic [31:0] rd);
    int k;
    for (int j = 0; j < n; j++) begin
      k = 0;
      while (up_rsp[ord[j]].ready !== 1'b1 && k < 40) begin
        @(posedge clk);
        k++;
      end
      `CHK({up_rsp[3].ready, up_rsp[2].ready, up_rsp[1].ready, up_rsp[0].ready}, 4'(1 << ord[j]))
      if (k == 40) report_and_stop();
      `CHK(up_rsp[ord[j]].slverr, err)
      if (!err && !up_req[ord[j]].write) `CHK(up_rsp[ord[j]].rdata, rd)
      up_req[ord[j]].sel <= 1'b0;
      up_req[ord[j]].enable <= 1'b0;
    end
  endtask

  // bounded wait for a q-channel output pair
  task automatic waitq(input logic acc, input logic den);
    int k;
    k = 0;
    while ({qaccept_n, qdeny} !== {acc, den} && k < 20) begin
      @(posedge clk);
      k++;
    end
    `CHK({qaccept_n, qdeny}, {acc, den})
    if (k == 20) report_and_stop();
  endtask

  initial begin
    int ord[4];
    int n;
    repeat (4) @(posedge clk);
    `CHK({qaccept_n, qdeny, qactive, up_rsp[0].ready}, 4'h8)
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // table: owners answer in ascending index order
    foreach (rows[r]) begin
      n = 0;
      for (int i = 0; i < 4; i++) if (rows[r].mask[i]) begin
        ord[n] = i;
        n++;
      end
      raise(rows[r].mask, rows[r].addr, rows[r].write);
      collect(ord, n, rows[r].err, rows[r].rd);
      if (!rows[r].err) `CHK({seen.write, seen.addr}, {rows[r].write, rows[r].addr})
      if (rows[r].write) `CHK(seen.wdata, ~rows[r].addr)
      @(posedge clk);
    end
    // later request of a lower index still wins over an older one
    raise(4'h1, 32'h0000_3000, 1'b0);
    raise(4'h8, 32'h0000_3000, 1'b0);
    raise(4'h2, 32'h0000_3000, 1'b0);
    collect('{0, 1, 3, 0}, 3, 1'b0, 32'hC0DE_0003);
    // q-channel accepted when idle, denied while a transfer runs
    qreq_n <= 1'b0;
    waitq(1'b0, 1'b0);
    `CHK(qactive, 1'b0)
    // a request made while stopped waits for the clock to come back
    raise(4'h1, 32'h0000_3000, 1'b0);
    repeat (3) @(posedge clk);
    `CHK({qactive, qaccept_n, up_rsp[0].ready}, 3'h4)
    qreq_n <= 1'b1;
    waitq(1'b1, 1'b0);
    collect('{0, 0, 0, 0}, 1, 1'b0, 32'hC0DE_0003);
    @(posedge clk);
    raise(4'h1, 32'h0000_3000, 1'b0);
    qreq_n <= 1'b0;
    waitq(1'b1, 1'b1);
    collect('{0, 0, 0, 0}, 1, 1'b0, 32'hC0DE_0003);
    qreq_n <= 1'b1;
    waitq(1'b1, 1'b0);
    // reset in mid transfer drops everything, then work resumes at once
    raise(4'h1, 32'h0000_3000, 1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    up_req <= '0;
    @(posedge clk);
    `CHK({qaccept_n, qdeny, qactive, |up_rsp, |dn_req}, 5'h10)
    rst_n <= 1'b1;
    raise(4'h4, 32'h0000_0010, 1'b0);
    collect('{2, 0, 0, 0}, 1, 1'b0, 32'hC0DE_0000);
    report_and_stop();
  end
endmodule // tb_top
